// *** dv/eep_host_asserts.sv ***
// Pin-level checks on the EEPROM host controller, bound to its top.
// Assumes one clock domain and the synchronous active-high reset.
`default_nettype none

module eep_host_asserts #(
	parameter int WC_LIMIT_CYC = 250000
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic rsp_valid,
	input wire logic write_done,
	input wire logic write_timeout,
	input wire logic protected_mode,
	input wire logic dev_busy,
	input wire logic [12:0] mem_addr,
	input wire logic [7:0] mem_dout,
	input wire logic mem_dout_oe,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic protect_reset_n,
	input wire logic mem_busy_n
);
	// ==================================================================
	// Load spacing tracker
	// ==================================================================
	logic [15:0] gap_q, gap_d;
	logic rd_seen_q, rd_seen_d;
	logic we_prev_q;

	// A read between two loads means a new operation, so no gap limit
	always_comb begin
		gap_d = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
		rd_seen_d = rd_seen_q | ~mem_oe_n;
		if (we_prev_q && !mem_we_n) begin
			gap_d = 16'h0000;
			rd_seen_d = 1'b0;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (reset) begin
			gap_q <= 16'h0000;
			rd_seen_q <= 1'b1;
			we_prev_q <= 1'b1;
		end else begin
			gap_q <= gap_d;
			rd_seen_q <= rd_seen_d;
			we_prev_q <= mem_we_n;
		end
	end

	// ==================================================================
	// Assertions
	// ==================================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_we_width: assert property ($fell(mem_we_n) |->
		(!mem_we_n && !mem_ce_n)[*5] ##1 (mem_we_n && mem_ce_n))
		else $error("write strobe width wrong");
	a_wr_qualify: assert property (!mem_we_n |->
		mem_oe_n && !mem_ce_n && mem_dout_oe)
		else $error("write strobe without proper qualifiers");
	a_wr_stable: assert property (!mem_we_n && $past(!mem_we_n) |->
		$stable(mem_addr) && $stable(mem_dout))
		else $error("address or data moved during load");
	a_data_hold: assert property ($rose(mem_we_n) |->
		mem_dout_oe && $stable(mem_dout))
		else $error("data released at strobe rise");
	a_res_high: assert property (!(mem_we_n && mem_oe_n) |->
		protect_reset_n)
		else $error("access while protect reset low");
	a_rd_width: assert property ($fell(mem_oe_n) |->
		(!mem_oe_n && mem_we_n && !mem_dout_oe)[*5] ##1 mem_oe_n)
		else $error("read cycle shape wrong");
	a_load_gap: assert property ($fell(mem_we_n) && !rd_seen_q |->
		gap_q < 16'h02EE)
		else $error("page byte load started too late");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("read response longer than one cycle");
	a_done_pulse: assert property (write_done |=> !write_done)
		else $error("write done longer than one cycle");
	a_busy_sync: assert property (dev_busy == !$past(mem_busy_n, 3))
		else $error("busy status not tracking busy pin");

	c_read: cover property (rsp_valid);
	c_prot_write: cover property (write_done && protected_mode);
	c_timeout: cover property (write_timeout);
	c_park: cover property ($fell(protect_reset_n));
endmodule

bind eep_host eep_host_asserts #(.WC_LIMIT_CYC(WC_LIMIT_CYC)) u_chk (
	.clk, .reset, .rsp_valid, .write_done, .write_timeout,
	.protected_mode, .dev_busy, .mem_addr, .mem_dout, .mem_dout_oe,
	.mem_ce_n, .mem_oe_n, .mem_we_n, .protect_reset_n, .mem_busy_n);

`default_nettype wire

// *** dv/eep_mem_model.sv ***
// Behavioural model of the byte-wide EEPROM on the host's pins.
// Assumes the bench pulls the busy line up and supplies the clock.
`default_nettype none

module eep_mem_model (
	input wire logic clk,
	input wire logic [12:0] mem_addr,
	input wire logic [7:0] mem_dout,
	input wire logic mem_dout_oe,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic protect_reset_n,
	input wire logic [7:0] prog_us,
	output logic [7:0] mem_din,
	output logic busy_pull
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==================================================================
	// Array, load list and status
	// ==================================================================
	logic [7:0] mem [0:8191];
	logic [20:0] ld [$];
	logic prot_q = 1'b0;
	logic busy = 1'b0;
	logic loading = 1'b0;
	logic tog = 1'b0;
	logic [7:0] last_d = 8'h00;
	logic [7:0] last_bus = 8'h00;
	logic [12:0] a_lat;
	logic drv;
	logic [7:0] rq;
	time t_fall = 0;
	time t_last = 0;
	time t_end = 0;
	int k = 0;
	wire logic stb = mem_ce_n | mem_we_n;

	// Erased array
	initial foreach (mem[i]) mem[i] = 8'hFF;

	function automatic logic is_ld(int i, logic [12:0] a, logic [7:0] d);
		return i < ld.size() && ld[i] === {a, d};
	endfunction

	// Address on the later fall, data on the earlier rise
	always @(negedge stb) begin
		a_lat = mem_addr;
		t_fall = $time;
	end

	// Short pulses and loads while busy, parked or read-enabled are lost
	always @(posedge stb) begin
		if ($time - t_fall > 20 && mem_oe_n && protect_reset_n
			&& !busy) begin
			ld.push_back({a_lat, mem_din});
			last_d = mem_din;
			t_last = $time;
			loading = 1'b1;
		end
	end

	// Self-start after the idle window; command loads are never stored.
	// Falling edge, so busy and status never move where the host samples
	always @(negedge clk) begin
		if (loading && stb && $time - t_last >= 100000) begin
			loading = 1'b0;
			busy = 1'b1;
			t_end = $time + prog_us * 1000;
			k = prot_q ? ld.size() : 0;
			if (is_ld(0, 13'h1555, 8'hAA) && is_ld(1, 13'h0AAA, 8'h55)) begin
				if (is_ld(2, 13'h1555, 8'hA0)) begin
					prot_q = 1'b1;
					k = 3;
				end else if (is_ld(2, 13'h1555, 8'h80) &&
					is_ld(3, 13'h1555, 8'hAA) && is_ld(4, 13'h0AAA, 8'h55) &&
					is_ld(5, 13'h1555, 8'h20)) begin
					prot_q = 1'b0;
					k = ld.size();
				end
			end
		end
		if (busy && !protect_reset_n) begin
			ld.delete();
			busy = 1'b0;
		end else if (busy && $time >= t_end) begin
			for (int i = k; i < ld.size(); i++) begin
				mem[ld[i][20:8]] = ld[i][7:0];
			end
			ld.delete();
			busy = 1'b0;
		end
	end

	// Each read start while programming flips the toggle bit
	always @(negedge (mem_ce_n | mem_oe_n)) begin
		if (busy && mem_we_n && protect_reset_n) begin
			tog = ~tog;
		end
	end

	// Bus level: host, device, or a changing value when nobody drives
	assign drv = !mem_ce_n && !mem_oe_n && mem_we_n && protect_reset_n;
	assign rq = busy ? {~last_d[7], tog, 6'h2A} : mem[mem_addr];
	assign mem_din = mem_dout_oe ? mem_dout : (drv ? rq : ~last_bus);
	assign busy_pull = busy | loading;
	always @(posedge clk) begin
		if (drv) begin
			last_bus <= rq;
		end
	end
endmodule

`default_nettype wire

// *** dv/tb_eep_host.sv ***
// Self-checking bench for the EEPROM host controller and a device model.
// Assumes a 25 MHz clock and a shortened completion limit.
`default_nettype none

module tb_eep_host;
	timeunit 1ns;
	timeprecision 1ns;

	// ==================================================================
	// Signals and instances
	// ==================================================================
	logic clk, reset, req_valid, req_last, park;
	logic [1:0] req_op;
	logic [12:0] req_addr, mem_addr;
	logic [7:0] req_data, rsp_data, mem_dout, mem_din, prog_us;
	logic req_ready, rsp_valid, write_done, write_timeout, protected_mode;
	logic dev_busy, mem_dout_oe, mem_ce_n, mem_oe_n, mem_we_n;
	logic protect_reset_n, busy_pull;
	wire logic mem_busy_n = busy_pull ? 1'b0 : 1'b1; // Pull-up
	int n_mismatch = 0;
	int tests_run = 0;

	eep_host #(.WC_LIMIT_CYC(2000)) u_dut (.clk, .reset, .req_valid,
		.req_op, .req_addr, .req_data, .req_last, .req_ready, .rsp_valid,
		.rsp_data, .write_done, .write_timeout, .protected_mode, .dev_busy,
		.park, .mem_addr, .mem_dout, .mem_dout_oe, .mem_din, .mem_ce_n,
		.mem_oe_n, .mem_we_n, .protect_reset_n, .mem_busy_n);
	eep_mem_model u_mem (.clk, .mem_addr, .mem_dout, .mem_dout_oe,
		.mem_ce_n, .mem_oe_n, .mem_we_n, .protect_reset_n, .prog_us,
		.mem_din, .busy_pull);

	// ==================================================================
	// Shared tasks
	// ==================================================================
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	// Hold the request until ready is seen, then drop it after the take
	task automatic send(input logic [1:0] op, input logic [12:0] a,
		input logic [7:0] d, input logic l);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_data <= d;
		req_last <= l;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 4000);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask

	// Wait for a result pulse: bit 0 read, 1 done, 2 timeout
	task automatic await(input int lim, output logic [2:0] g);
		int n;
		n = 0;
		g = 3'h0;
		while (g === 3'h0 && n < lim) begin
			@(negedge clk);
			n++;
			g = {write_timeout, write_done, rsp_valid};
		end
	endtask

	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		logic [2:0] g;
		send(2'h0, a, 8'h00, 1'b0);
		await(50, g);
		chk8({5'h00, g}, 8'h01);
		chk8(rsp_data, exp);
	endtask

	task automatic fin(input logic [2:0] exp);
		logic [2:0] g;
		await(8000, g);
		chk8({5'h00, g}, {5'h00, exp});
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	// ==================================================================
	task automatic t_park;
		@(posedge clk);
		park <= 1'b1;
		repeat (4) @(negedge clk);
		chk1(protect_reset_n, 1'b0);
		chk1(req_ready, 1'b0);
		@(posedge clk);
		park <= 1'b0;
		repeat (40) @(negedge clk);
		chk1(protect_reset_n, 1'b1);
	endtask

	// Full page with a boundary count, then busy pin and read-back
	task automatic t_page;
		for (int i = 0; i < 32; i++) begin
			send(2'h1, 13'h0040 + 13'(i), 8'(i) ^ 8'h5A, i == 31);
		end
		repeat (5) @(negedge clk);
		chk1(dev_busy, 1'b1);
		fin(3'h2);
		chk1(dev_busy, 1'b0);
		for (int i = 0; i < 32; i++) begin
			rd(13'h0040 + 13'(i), 8'(i) ^ 8'h5A);
		end
	endtask

	// Slow then overlong programming
	task automatic t_slow;
		logic tg;
		prog_us <= 8'h3C;
		send(2'h1, 13'h0123, 8'hC3, 1'b1);
		fin(3'h2);
		rd(13'h0123, 8'hC3);
		prog_us <= 8'h78;
		send(2'h1, 13'h0200, 8'h81, 1'b1);
		fin(3'h4);
		// Device still busy: status reads show poll and toggle bits
		send(2'h0, 13'h0200, 8'h00, 1'b0);
		fin(3'h1);
		chk1(rsp_data[7], 1'b0);
		tg = rsp_data[6];
		send(2'h0, 13'h0200, 8'h00, 1'b0);
		fin(3'h1);
		chk1(rsp_data[6], !tg);
		repeat (1200) @(negedge clk);
		rd(13'h0200, 8'h81);
		prog_us <= 8'h04;
	endtask

	// Protection on, protected write, protection off
	task automatic t_prot;
		chk1(u_mem.prot_q, 1'b0);
		send(2'h2, 13'h0000, 8'h00, 1'b1);
		fin(3'h2);
		chk1(protected_mode, 1'b1);
		chk1(u_mem.prot_q, 1'b1);
		send(2'h1, 13'h0300, 8'h3C, 1'b1);
		fin(3'h2);
		rd(13'h0300, 8'h3C);
		send(2'h3, 13'h0000, 8'h00, 1'b1);
		fin(3'h2);
		chk1(protected_mode, 1'b0);
		chk1(u_mem.prot_q, 1'b0);
		rd(13'h1555, 8'hFF);
		rd(13'h0AAA, 8'hFF);
	endtask

	// ==================================================================
	// Clock, watchdog, main sequence
	// ==================================================================
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Whole run needs about 21000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_addr = 13'h0000;
		req_data = 8'h00;
		req_last = 1'b0;
		park = 1'b0;
		prog_us = 8'h04;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(negedge clk);
		chk1(protected_mode, 1'b0);
		t_park();
		t_page();
		t_slow();
		t_prot();
		stop_test();
	end
endmodule

`default_nettype wire

// *** hw/eep_bus_cycle.sv ***
// One strobed access on the EEPROM pins: a byte load or a byte read.
// Assumes the caller pulses start only while no access is running.
`default_nettype none

module eep_bus_cycle
	import eep_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic rd_not_wr,
	input wire logic [12:0] addr_in,
	input wire logic [7:0] data_in,
	output logic done,
	output logic [7:0] rd_data,
	output logic [12:0] mem_addr,
	output logic [7:0] mem_dout,
	output logic mem_dout_oe,
	input wire logic [7:0] mem_din,
	output logic mem_ce_n,
	output logic mem_oe_n,
	output logic mem_we_n
);

	// ======================================================================
	// State
	// ======================================================================
	typedef enum logic [2:0] {SQ_IDLE, SQ_WSTB, SQ_WHOLD, SQ_REC, SQ_RD}
		eep_sq_t;
	eep_sq_t st_q, st_d;
	logic [SQ_CNT_W-1:0] cnt_q, cnt_d;
	logic [12:0] addr_q, addr_d;
	logic [7:0] dout_q, dout_d, rdata_q, rdata_d;
	logic doe_q, doe_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d, done_q, done_d;
	logic [7:0] din_s1_q, din_s2_q;

	// Next values; strobes only change here so every edge is glitch free
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 1'b1;
		addr_d = addr_q;
		dout_d = dout_q;
		rdata_d = rdata_q;
		doe_d = doe_q;
		ce_d = ce_q;
		oe_d = oe_q;
		we_d = we_q;
		done_d = 1'b0;
		unique case (st_q)
			SQ_IDLE: begin
				cnt_d = '0;
				if (start) begin
					addr_d = addr_in;
					dout_d = data_in;
					ce_d = 1'b0;
					if (rd_not_wr) begin
						oe_d = 1'b0;
						st_d = SQ_RD;
					end else begin
						// Output drive stays high through every load
						oe_d = 1'b1;
						// CE and WE fall together: address taken there
						we_d = 1'b0;
						doe_d = 1'b1;
						st_d = SQ_WSTB;
					end
				end
			end
			SQ_WSTB: begin
				// Strobe held far beyond the device noise filter
				if (cnt_q == SQ_CNT_W'(WP_CYC - 1)) begin
					// Data stable well before this common rise
					we_d = 1'b1;
					ce_d = 1'b1;
					cnt_d = '0;
					st_d = SQ_WHOLD;
				end
			end
			SQ_WHOLD: begin
				if (cnt_q == SQ_CNT_W'(AH_CYC - 1)) begin
					doe_d = 1'b0;
					cnt_d = '0;
					st_d = SQ_REC;
				end
			end
			SQ_RD: begin
				if (cnt_q == SQ_CNT_W'(RD_CYC - 1)) begin
					rdata_d = din_s2_q;
					ce_d = 1'b1;
					oe_d = 1'b1;
					cnt_d = '0;
					st_d = SQ_REC;
				end
			end
			SQ_REC: begin
				// Recovery keeps the minimum load cycle and the bus float time
				if (cnt_q == SQ_CNT_W'(REC_CYC - 1)) begin
					done_d = 1'b1;
					st_d = SQ_IDLE;
				end
			end
		endcase
	end

	// Registers; the read data bus passes two flops before use
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= SQ_IDLE;
			cnt_q <= '0;
			addr_q <= '0;
			dout_q <= '0;
			rdata_q <= '0;
			doe_q <= 1'b0;
			ce_q <= 1'b1;
			oe_q <= 1'b1;
			we_q <= 1'b1;
			done_q <= 1'b0;
			din_s1_q <= '0;
			din_s2_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			rdata_q <= rdata_d;
			doe_q <= doe_d;
			ce_q <= ce_d;
			oe_q <= oe_d;
			we_q <= we_d;
			done_q <= done_d;
			din_s1_q <= mem_din;
			din_s2_q <= din_s1_q;
		end
	end

	assign done = done_q;
	assign rd_data = rdata_q;
	assign mem_addr = addr_q;
	assign mem_dout = dout_q;
	assign mem_dout_oe = doe_q;
	assign mem_ce_n = ce_q;
	assign mem_oe_n = oe_q;
	assign mem_we_n = we_q;

endmodule

`default_nettype wire

// *** hw/eep_host.sv ***
// Host controller for a byte-wide parallel EEPROM: reads, page writes,
// software protection sequences and completion polling.
// Assumes a user port on clk and the EEPROM pins wired directly; the busy
// pin is open drain with an external pull-up.
`default_nettype none

module eep_host
	import eep_pkg::*;
#(
	parameter int WC_LIMIT_CYC = WC_CYC
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [12:0] req_addr,
	input wire logic [7:0] req_data,
	input wire logic req_last,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic write_done,
	output logic write_timeout,
	output logic protected_mode,
	output logic dev_busy,
	input wire logic park,
	output logic [12:0] mem_addr,
	output logic [7:0] mem_dout,
	output logic mem_dout_oe,
	input wire logic [7:0] mem_din,
	output logic mem_ce_n,
	output logic mem_oe_n,
	output logic mem_we_n,
	output logic protect_reset_n,
	input wire logic mem_busy_n
);

	// ======================================================================
	// State
	// ======================================================================
	typedef enum logic [3:0] {ST_IDLE, ST_CMD, ST_DATA, ST_GAP, ST_WINDOW,
		ST_POLL_A, ST_POLL_B, ST_READ, ST_PARK, ST_WAKE} eep_st_t;
	eep_st_t st_q, st_d;
	logic [2:0] idx_q, idx_d;
	logic [5:0] cnt_q, cnt_d;
	logic [1:0] op_q, op_d;
	logic [12:0] addr_q, addr_d;
	logic [7:0] data_q, data_d, rsp_data_q, rsp_data_d;
	logic last_q, last_d, sent_q, sent_d, prot_q, prot_d, tog_q, tog_d;
	logic ready_q, ready_d, rsp_valid_q, rsp_valid_d;
	logic done_q, done_d, err_q, err_d, resn_q, resn_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic tmr_clr;
	logic busy_s1_q, busy_s2_q, dev_busy_q;
	logic seq_start, seq_rd, seq_done;
	logic [12:0] seq_addr;
	logic [7:0] seq_data, seq_rdata;
	logic [15:0] cmd_a;
	logic taken;

	assign taken = req_valid && ready_q;
	assign cmd_a = cmd_addr(op_q == OP_PROT_OFF, idx_q);

	// ======================================================================
	// Pin sequencer
	// ======================================================================
	eep_bus_cycle u_cycle (
		.clk(clk),
		.reset(reset),
		.start(seq_start),
		.rd_not_wr(seq_rd),
		.addr_in(seq_addr),
		.data_in(seq_data),
		.done(seq_done),
		.rd_data(seq_rdata),
		.mem_addr(mem_addr),
		.mem_dout(mem_dout),
		.mem_dout_oe(mem_dout_oe),
		.mem_din(mem_din),
		.mem_ce_n(mem_ce_n),
		.mem_oe_n(mem_oe_n),
		.mem_we_n(mem_we_n)
	);

	// ======================================================================
	// Transfer control
	// ======================================================================
	// Next values of the control machine
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		op_d = op_q;
		addr_d = addr_q;
		data_d = data_q;
		last_d = last_q;
		sent_d = sent_q;
		prot_d = prot_q;
		tog_d = tog_q;
		ready_d = ready_q;
		rsp_valid_d = 1'b0;
		rsp_data_d = rsp_data_q;
		done_d = 1'b0;
		err_d = 1'b0;
		resn_d = 1'b1;
		tmr_clr = 1'b0;
		seq_start = 1'b0;
		seq_rd = 1'b0;
		seq_addr = addr_q;
		seq_data = data_q;
		unique case (st_q)
			ST_IDLE: begin
				if (taken) begin
					op_d = req_op;
					addr_d = req_addr;
					data_d = req_data;
					last_d = req_last;
					ready_d = 1'b0;
					cnt_d = '0;
					idx_d = '0;
					if (req_op == OP_READ) begin
						st_d = ST_READ;
					end else if (req_op == OP_WRITE && !prot_q) begin
						st_d = ST_DATA;
					end else begin
						// Protected writes get the enable prefix first
						st_d = ST_CMD;
					end
				end else if (park) begin
					ready_d = 1'b0;
					st_d = ST_PARK;
				end else begin
					ready_d = 1'b1;
				end
			end
			ST_CMD: begin
				seq_addr = cmd_a[12:0];
				seq_data = cmd_data(op_q == OP_PROT_OFF, idx_q);
				seq_start = !sent_q;
				tmr_clr = !sent_q;
				sent_d = 1'b1;
				if (seq_done) begin
					sent_d = 1'b0;
					idx_d = idx_q + 3'h1;
					if (idx_q == ON_LAST_IDX && op_q != OP_PROT_OFF) begin
						idx_d = '0;
						st_d = (op_q == OP_WRITE) ? ST_DATA : ST_WINDOW;
					end else if (idx_q == OFF_LAST_IDX) begin
						// Nothing follows the cancel loads in its page
						idx_d = '0;
						st_d = ST_WINDOW;
					end
				end
			end
			ST_DATA: begin
				seq_start = !sent_q;
				tmr_clr = !sent_q;
				sent_d = 1'b1;
				if (seq_done) begin
					sent_d = 1'b0;
					cnt_d = cnt_q + 6'h1;
					// Page closes on the user's last byte or a full page
					if (last_q || cnt_q == 6'(PAGE_BYTES - 1)) begin
						st_d = ST_WINDOW;
					end else begin
						ready_d = 1'b1;
						st_d = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				if (taken) begin
					addr_d = req_addr;
					data_d = req_data;
					last_d = req_last;
					ready_d = 1'b0;
					st_d = ST_DATA;
				end else if (tmr_q >= TMR_W'(GAP_LIMIT_CYC)) begin
					// A late byte would land in a new write cycle; close now
					ready_d = 1'b0;
					st_d = ST_WINDOW;
				end
			end
			ST_WINDOW: begin
				// Strobes idle long enough for the device to self-start
				if (tmr_q >= TMR_W'(TBL_CYC + BLC_MIN_CYC)) begin
					tmr_clr = 1'b1;
					st_d = ST_POLL_A;
				end
			end
			ST_POLL_A: begin
				// Only status reads until the cycle ends; no new loads
				seq_rd = 1'b1;
				seq_start = !sent_q;
				sent_d = 1'b1;
				if (seq_done) begin
					sent_d = 1'b0;
					tog_d = seq_rdata[TOGGLE_STATUS_BIT];
					st_d = ST_POLL_B;
				end
			end
			ST_POLL_B: begin
				seq_rd = 1'b1;
				seq_start = !sent_q;
				sent_d = 1'b1;
				if (seq_done) begin
					sent_d = 1'b0;
					tog_d = seq_rdata[TOGGLE_STATUS_BIT];
					// Two equal reads in a row: programming is over
					if (seq_rdata[TOGGLE_STATUS_BIT] == tog_q) begin
						done_d = 1'b1;
						if (op_q == OP_PROT_ON) begin
							prot_d = 1'b1;
						end else if (op_q == OP_PROT_OFF) begin
							prot_d = 1'b0;
						end
						st_d = ST_IDLE;
					end else if (tmr_q >= TMR_W'(WC_LIMIT_CYC)) begin
						// Still toggling past the worst case: give up
						err_d = 1'b1;
						st_d = ST_IDLE;
					end
				end
			end
			ST_READ: begin
				seq_rd = 1'b1;
				seq_start = !sent_q;
				sent_d = 1'b1;
				if (seq_done) begin
					sent_d = 1'b0;
					rsp_valid_d = 1'b1;
					rsp_data_d = seq_rdata;
					st_d = ST_IDLE;
				end
			end
			ST_PARK: begin
				// Entered only from idle, so during programming only after a write timeout
				resn_d = 1'b0;
				if (!park) begin
					resn_d = 1'b1;
					tmr_clr = 1'b1;
					st_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// Device needs protect-reset high a while before access
				if (tmr_q >= TMR_W'(RES_HIGH_CYC)) begin
					st_d = ST_IDLE;
				end
			end
		endcase
	end

	// Saturating timer, cleared at each load start, at poll start and on leaving park
	always_comb begin
		if (tmr_clr) begin
			tmr_d = '0;
		end else if (tmr_q != '1) begin
			tmr_d = tmr_q + 1'b1;
		end else begin
			tmr_d = tmr_q;
		end
	end

	// Registers of the control machine
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= ST_IDLE;
			idx_q <= '0;
			cnt_q <= '0;
			op_q <= OP_READ;
			addr_q <= '0;
			data_q <= '0;
			last_q <= 1'b0;
			sent_q <= 1'b0;
			prot_q <= PROT_RESET;
			tog_q <= 1'b0;
			ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= '0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			resn_q <= 1'b1;
			tmr_q <= '0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			addr_q <= addr_d;
			data_q <= data_d;
			last_q <= last_d;
			sent_q <= sent_d;
			prot_q <= prot_d;
			tog_q <= tog_d;
			ready_q <= ready_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			done_q <= done_d;
			err_q <= err_d;
			resn_q <= resn_d;
			tmr_q <= tmr_d;
		end
	end

	// ======================================================================
	// Busy pin watch
	// ======================================================================
	// Open-drain busy is asynchronous, so it is synchronised first
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_s1_q <= 1'b1;
			busy_s2_q <= 1'b1;
			dev_busy_q <= 1'b0;
		end else begin
			busy_s1_q <= mem_busy_n;
			busy_s2_q <= busy_s1_q;
			dev_busy_q <= !busy_s2_q;
		end
	end

	assign req_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign write_done = done_q;
	assign write_timeout = err_q;
	assign protected_mode = prot_q;
	assign dev_busy = dev_busy_q;
	assign protect_reset_n = resn_q;

endmodule

`default_nettype wire

// *** hw/eep_pkg.sv ***
// ==========================================================================
// Constants, timing figures and command tables for the EEPROM host
// controller.
// Assumes a 25 MHz system clock and one byte-wide parallel EEPROM.
// ==========================================================================
// Overview of operation
// - Next load within 30 us of last
// - Hold protect-reset high during every access
// - Protect-reset high 10 ms after load (host allows park as soon as polling shows the write has ended)
// - Protected writes need three-load prefix
`default_nettype none

package eep_pkg;

	// ======================================================================
	// Clock and cycle timing
	// ======================================================================
	localparam int CLK_NS = 40;
	localparam int WP_NS = 200;
	localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int AH_NS = 50;
	localparam int AH_CYC = (AH_NS + CLK_NS - 1) / CLK_NS;
	localparam int BLC_MIN_NS = 300;
	localparam int BLC_MIN_CYC = (BLC_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_CYC = BLC_MIN_CYC - WP_CYC - AH_CYC;
	localparam int ACC_NS = 100;
	localparam int SYNC_CYC = 2;
	localparam int RD_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int BLC_MAX_US = 30;
	localparam int BLC_MAX_CYC = BLC_MAX_US * 1000 / CLK_NS;
	localparam int GAP_MARGIN_CYC = 32;
	localparam int GAP_LIMIT_CYC = BLC_MAX_CYC - GAP_MARGIN_CYC;
	localparam int TBL_US = 100;
	localparam int TBL_CYC = (TBL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WC_MS = 10;
	localparam int WC_CYC = WC_MS * 1000000 / CLK_NS;
	localparam int RES_HIGH_US = 1;
	localparam int RES_HIGH_CYC = (RES_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 18;
	localparam int SQ_CNT_W = 4;

	// ======================================================================
	// Page, status bits, operations, reset values
	// ======================================================================
	localparam int PAGE_BYTES = 32;
	localparam int TOGGLE_STATUS_BIT = 6;
	localparam int POLL_STATUS_BIT = 7;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_PROT_ON = 2'h2;
	localparam logic [1:0] OP_PROT_OFF = 2'h3;
	localparam logic [2:0] ON_LAST_IDX = 3'h2;
	localparam logic [2:0] OFF_LAST_IDX = 3'h5;
	localparam logic PROT_RESET = 1'b0;

	// ======================================================================
	// Command tables
	// ======================================================================
	localparam logic [15:0] CMD_ADDR_A = 16'h1555;
	localparam logic [15:0] CMD_ADDR_B = 16'h0AAA;
	localparam logic [15:0] CMD_ADDR_C = 16'h5555;
	localparam logic [7:0] CMD_KEY_1 = 8'hAA;
	localparam logic [7:0] CMD_KEY_2 = 8'h55;
	localparam logic [7:0] CMD_ENABLE = 8'hA0;
	localparam logic [7:0] CMD_PRE_OFF = 8'h80;
	localparam logic [7:0] CMD_OFF = 8'h20;

	// Address of load idx of the enable (off=0) or cancel (off=1) sequence
	function automatic logic [15:0] cmd_addr(input logic off,
		input logic [2:0] idx);
		logic [15:0] a;
		a = CMD_ADDR_A;
		unique case (idx)
			3'h1, 3'h4: a = CMD_ADDR_B;
			3'h2: a = off ? CMD_ADDR_A : CMD_ADDR_C;
			default: a = CMD_ADDR_A;
		endcase
		return a;
	endfunction

	// Data of load idx of the enable or cancel sequence
	function automatic logic [7:0] cmd_data(input logic off,
		input logic [2:0] idx);
		logic [7:0] d;
		d = CMD_KEY_1;
		unique case (idx)
			3'h1, 3'h4: d = CMD_KEY_2;
			3'h2: d = off ? CMD_PRE_OFF : CMD_ENABLE;
			3'h5: d = CMD_OFF;
			default: d = CMD_KEY_1;
		endcase
		return d;
	endfunction

endpackage

`default_nettype wire
